// ==== hdl/pcid_pad_cell.sv ====
// Pad cell: input path with programmable delay, output and tristate paths.
// Assumes fabric signals share clock_i; the pad input is asynchronous.
// Configuration inputs are sampled once, at the first edge after reset.
`timescale 1ns/1ps
`default_nettype none
module pcid_pad_cell
    import pcid_pkg::*;
#(
    parameter bit HAS_OUTPUT = 1'b1
)(
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Pad
    input wire logic pad_in_i,
    output logic pad_out_o,
    output logic pad_oe_n_o,
    // Fabric data and controls
    input wire logic out_data_first_i,
    input wire logic out_data_second_i,
    input wire logic tristate_ctl_first_i,
    input wire logic tristate_ctl_second_i,
    input wire logic in_gate_first_i,
    input wire logic in_gate_second_i,
    input wire logic out_gate_first_i,
    input wire logic out_gate_second_i,
    input wire logic tri_gate_first_i,
    input wire logic tri_gate_second_i,
    input wire logic set_reset_i,
    // Static configuration
    input wire logic cfg_coarse_en_i,
    input wire logic [2:0] cfg_direct_tap_i,
    input wire logic [1:0] cfg_reg_tap_i,
    input wire logic [INV_W-1:0] cfg_invert_i,
    input wire logic [LATCH_W-1:0] cfg_latch_i,
    input wire logic cfg_out_reg_i,
    input wire logic cfg_out_second_i,
    input wire logic cfg_tri_reg_i,
    input wire logic cfg_tri_second_i,
    // Fabric results
    output logic direct_o,
    output logic captured_first_o,
    output logic captured_second_o
);
    // ------------------------------------------------------------------
    // Configuration capture
    // ------------------------------------------------------------------
    logic cfg_loaded;
    logic coarse_en;
    logic [2:0] direct_tap;
    logic [1:0] reg_tap;
    logic [INV_W-1:0] inv;
    logic [LATCH_W-1:0] latch;
    logic out_reg;
    logic out_second;
    logic tri_reg;
    logic tri_second;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_loaded <= 1'h0;
            coarse_en <= 1'h0;
            direct_tap <= 3'h0;
            reg_tap <= 2'h0;
            inv <= '0;
            latch <= '0;
            out_reg <= 1'h0;
            out_second <= 1'h0;
            tri_reg <= 1'h0;
            tri_second <= 1'h0;
        end else if (!cfg_loaded) begin
            cfg_loaded <= 1'h1;
            coarse_en <= cfg_coarse_en_i;
            direct_tap <= cfg_direct_tap_i;
            reg_tap <= cfg_reg_tap_i;
            inv <= cfg_invert_i;
            latch <= cfg_latch_i;
            out_reg <= cfg_out_reg_i;
            out_second <= cfg_out_second_i;
            tri_reg <= cfg_tri_reg_i;
            tri_second <= cfg_tri_second_i;
        end
    end

    // Selector 7 is beyond the line and reads the last tap.
    function automatic logic [2:0] direct_index(input logic [2:0] sel);
        direct_index = (sel > TAP_LAST) ? TAP_LAST : sel;
    endfunction

    // Only three taps reach the storage inputs.
    function automatic logic [2:0] reg_index(input logic [1:0] sel);
        case (sel)
            2'h0: reg_index = REG_TAP_A;
            2'h1: reg_index = REG_TAP_B;
            default: reg_index = REG_TAP_C;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Input synchroniser and delay line
    // ------------------------------------------------------------------
    logic pad_meta;
    logic pad_sync;
    logic pad_val;
    logic [COARSE_LEN-1:0] coarse;
    logic line_in;
    logic [TAP_COUNT-1:0] tap;
    logic in_d;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pad_meta <= 1'h0;
            pad_sync <= 1'h0;
        end else begin
            pad_meta <= pad_in_i;
            pad_sync <= pad_meta;
        end
    end

    assign pad_val = pad_sync ^ inv[INV_PAD];

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            coarse <= '0;
        end else begin
            coarse <= {coarse[COARSE_LEN-2:0], pad_val};
        end
    end

    // One coarse choice feeds both consumers of the line.
    assign line_in = coarse_en ? coarse[COARSE_LEN-1] : pad_val;

    genvar t;
    generate
        for (t = 0; t < TAP_COUNT; t++) begin : g_tap
            always_ff @(posedge clock_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    tap[t] <= 1'h0;
                end else if (t == 0) begin
                    tap[t] <= line_in;
                end else begin
                    tap[t] <= tap[(t == 0) ? 0 : t-1];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            direct_o <= 1'h0;
        end else begin
            direct_o <= tap[direct_index(direct_tap)];
        end
    end

    assign in_d = tap[reg_index(reg_tap)];

    // ------------------------------------------------------------------
    // Input storage pair
    // ------------------------------------------------------------------
    logic sr;

    assign sr = set_reset_i ^ inv[INV_SR];

    pcid_store_pair u_in_pair (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .d_first_i(in_d),
        .d_second_i(in_d),
        .gate_first_i(in_gate_first_i ^ inv[INV_IG1]),
        .gate_second_i(in_gate_second_i ^ inv[INV_IG2]),
        .latch_mode_i(latch[LATCH_IN+1:LATCH_IN]),
        .sr_i(sr),
        .q_first_o(captured_first_o),
        .q_second_o(captured_second_o)
    );

    // ------------------------------------------------------------------
    // Output and tristate paths
    // ------------------------------------------------------------------
    generate
        if (HAS_OUTPUT) begin : g_out
            logic od1;
            logic od2;
            logic tc1;
            logic tc2;
            logic oq1;
            logic oq2;
            logic tq1;
            logic tq2;
            logic out_mux;
            logic tri_mux;

            assign od1 = out_data_first_i ^ inv[INV_OD1];
            assign od2 = out_data_second_i ^ inv[INV_OD2];
            assign tc1 = tristate_ctl_first_i ^ inv[INV_TC1];
            assign tc2 = tristate_ctl_second_i ^ inv[INV_TC2];

            pcid_store_pair u_out_pair (
                .clock_i(clock_i),
                .nrst_i(nrst_i),
                .d_first_i(od1),
                .d_second_i(od2),
                .gate_first_i(out_gate_first_i ^ inv[INV_OG1]),
                .gate_second_i(out_gate_second_i ^ inv[INV_OG2]),
                .latch_mode_i(latch[LATCH_OUT+1:LATCH_OUT]),
                .sr_i(sr),
                .q_first_o(oq1),
                .q_second_o(oq2)
            );

            pcid_store_pair u_tri_pair (
                .clock_i(clock_i),
                .nrst_i(nrst_i),
                .d_first_i(tc1),
                .d_second_i(tc2),
                .gate_first_i(tri_gate_first_i ^ inv[INV_TG1]),
                .gate_second_i(tri_gate_second_i ^ inv[INV_TG2]),
                .latch_mode_i(latch[LATCH_TRI+1:LATCH_TRI]),
                .sr_i(sr),
                .q_first_o(tq1),
                .q_second_o(tq2)
            );

            always_comb begin
                out_mux = out_reg ? (out_second ? oq2 : oq1)
                                  : (out_second ? od2 : od1);
                tri_mux = tri_reg ? (tri_second ? tq2 : tq1)
                                  : (tri_second ? tc2 : tc1);
            end

            // A high tristate value releases the pad; drive only once set up.
            always_ff @(posedge clock_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    pad_out_o <= OUT_RESET;
                    pad_oe_n_o <= OE_N_RESET;
                end else begin
                    pad_out_o <= out_mux;
                    pad_oe_n_o <= tri_mux | ~cfg_loaded;
                end
            end

            out_direct_a: assert property (@(posedge clock_i)
                disable iff (!nrst_i)
                (cfg_loaded && !out_reg && !out_second)
                |=> (pad_out_o == $past(od1)))
                else $error("direct output path lost its data");
            tri_direct_a: assert property (@(posedge clock_i)
                disable iff (!nrst_i)
                (cfg_loaded && !tri_reg && tri_second)
                |=> (pad_oe_n_o == $past(tc2)))
                else $error("tristate path chose the wrong control");
        end else begin : g_in_only
            // No driver: the pad is never enabled.
            always_ff @(posedge clock_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    pad_out_o <= OUT_RESET;
                    pad_oe_n_o <= OE_N_RESET;
                end else begin
                    pad_out_o <= OUT_RESET;
                    pad_oe_n_o <= OE_N_RESET;
                end
            end

            in_only_a: assert property (@(posedge clock_i)
                disable iff (!nrst_i) pad_oe_n_o && !pad_out_o)
                else $error("input-only cell drove its pad");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [3:0] run;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            run <= 4'h0;
        end else if (run != 4'hF) begin
            run <= run + 4'h1;
        end
    end

    cfg_frozen_a: assert property (@(posedge clock_i)
        disable iff (!nrst_i) cfg_loaded |=> ($stable(direct_tap)
            && $stable(reg_tap) && $stable(coarse_en)))
        else $error("delay selection changed in operation");
    short_direct_a: assert property (@(posedge clock_i)
        disable iff (!nrst_i) (run == 4'hF && !coarse_en
            && direct_tap == 3'h0) |-> (direct_o == $past(pad_val, 2)))
        else $error("shortest direct delay is wrong");
    long_direct_a: assert property (@(posedge clock_i)
        disable iff (!nrst_i) (run == 4'hF && coarse_en
            && direct_tap == 3'h6) |-> (direct_o == $past(pad_val, 12)))
        else $error("longest direct delay is wrong");
    reg_tap_a: assert property (@(posedge clock_i)
        disable iff (!nrst_i) (run == 4'hF && !coarse_en && reg_tap == 2'h1)
        |-> (in_d == $past(pad_val, 4)))
        else $error("registered path took the wrong tap");
    shared_coarse_a: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        (run == 4'hF && coarse_en && reg_tap == 2'h0)
        |-> (in_d == $past(pad_val, 5)))
        else $error("coarse element not shared");
    pad_invert_a: assert property (@(posedge clock_i)
        disable iff (!nrst_i) (run == 4'hF && inv[INV_PAD] && !coarse_en
            && direct_tap == 3'h0) |-> (direct_o != $past(pad_sync, 2)))
        else $error("pad inversion not applied");
endmodule
`default_nettype wire

// ==== hdl/pcid_store_pair.sv ====
// One pair of storage elements for a pad cell path.
// Assumes gates and data come from logic on the same clock, already inverted.
`timescale 1ns/1ps
`default_nettype none
module pcid_store_pair
    import pcid_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Data and gates
    input wire logic d_first_i,
    input wire logic d_second_i,
    input wire logic gate_first_i,
    input wire logic gate_second_i,
    // Options and forced clear
    input wire logic [1:0] latch_mode_i,
    input wire logic sr_i,
    // Stored values
    output logic q_first_o,
    output logic q_second_o
);
    logic [1:0] gate_prev;
    logic [1:0] gate_now;
    logic [1:0] d_now;
    logic [1:0] q;
    logic [1:0] load;

    assign gate_now = {gate_second_i, gate_first_i};
    assign d_now = {d_second_i, d_first_i};

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gate_prev <= 2'h0;
        end else begin
            gate_prev <= gate_now;
        end
    end

    // A register loads on the rising gate; a latch follows while gate is high.
    genvar k;
    generate
        for (k = 0; k < 2; k++) begin : g_elem
            assign load[k] = latch_mode_i[k] ? gate_now[k]
                                             : gate_now[k] & ~gate_prev[k];
            always_ff @(posedge clock_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    q[k] <= 1'h0;
                end else if (sr_i) begin
                    q[k] <= 1'h0;
                end else if (load[k]) begin
                    q[k] <= d_now[k];
                end
            end
        end
    endgenerate

    assign q_first_o = q[0];
    assign q_second_o = q[1];

    edge_load_a: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        (!sr_i && !latch_mode_i[0] && gate_first_i && !gate_prev[0])
        |=> (q_first_o == $past(d_first_i)))
        else $error("register element missed its load edge");
    latch_follow_a: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        (!sr_i && latch_mode_i[1] && gate_second_i) [*2]
        |=> (q_second_o == $past(d_second_i)))
        else $error("latch element did not follow its data");
    clear_hold_a: assert property (@(posedge clock_i)
        disable iff (!nrst_i) sr_i |=> (q == 2'h0))
        else $error("forced clear did not clear the pair");
endmodule
`default_nettype wire

// ==== shared/pcid_pkg.sv ====
// Constants shared by the pad cell and its storage pair.
// Assumes a single 40 MHz clock and static configuration inputs.
// Behaviour
// - Pad signal passes optional delay to a direct registered fabric output.
// - Delayed pad signal also feeds a storage pair driving two captured outputs.
// - Output path muxes two fabric data bits, optionally through a storage pair.
// - Tristate path muxes two fabric controls, optionally stored, to set high impedance.
// - Each path owns a storage pair, each element register or latch.
// - Every pad and fabric signal entering the cell has a selectable inversion inside the cell.
// - Input-only variant keeps only the input path, no driver logic.
// - Input delay is a coarse element followed by a seven-tap line.
// - Direct input selects any of seven taps, fourteen settings with coarse choice.
// - Registered input selects three taps only, six settings with coarse choice.
// - Coarse element is shared: used by both paths or bypassed by both.
// - Tap selections are fixed at configuration and never change in operation.
package pcid_pkg;
    localparam int CLOCK_HZ = 40_000_000;
    // Delay stages, each one clock period long.
    localparam int COARSE_LEN = 4;
    localparam int TAP_COUNT = 7;
    localparam logic [2:0] TAP_LAST = 3'h6;
    // Taps reachable from the registered path.
    localparam logic [2:0] REG_TAP_A = 3'h0;
    localparam logic [2:0] REG_TAP_B = 3'h3;
    localparam logic [2:0] REG_TAP_C = 3'h6;
    // Inversion vector bit positions.
    localparam int INV_W = 12;
    localparam int INV_PAD = 0;
    localparam int INV_OD1 = 1;
    localparam int INV_OD2 = 2;
    localparam int INV_TC1 = 3;
    localparam int INV_TC2 = 4;
    localparam int INV_IG1 = 5;
    localparam int INV_IG2 = 6;
    localparam int INV_OG1 = 7;
    localparam int INV_OG2 = 8;
    localparam int INV_TG1 = 9;
    localparam int INV_TG2 = 10;
    localparam int INV_SR = 11;
    // Latch option vector: two bits per path, first element in the low bit.
    localparam int LATCH_W = 6;
    localparam int LATCH_IN = 0;
    localparam int LATCH_OUT = 2;
    localparam int LATCH_TRI = 4;
    // Output values shown after reset.
    localparam logic OUT_RESET = 1'h0;
    localparam logic OE_N_RESET = 1'h1;
endpackage

// ==== verif/pcid_far_side.sv ====
// Far side of the pad cell: the package pin with its board pull-up.
// Assumes the bench plays the external driver through drive_en_i/level_i.
`timescale 1ns/1ps
`default_nettype none
module pcid_far_side (
    // Pad cell drive
    input wire logic pad_out_i,
    input wire logic pad_oe_n_i,
    // External driver
    input wire logic drive_en_i,
    input wire logic level_i,
    // Resolved pin level
    output logic pad_in_o
);
    // An undriven pin floats up to the pull-up level.
    always_comb begin
        if (!pad_oe_n_i) begin
            pad_in_o = pad_out_i;
        end else if (drive_en_i) begin
            pad_in_o = level_i;
        end else begin
            pad_in_o = 1'h1;
        end
    end
endmodule
`default_nettype wire

// ==== verif/pcid_pad_cell_bench.sv ====
// Self-checking bench for the pad cell and its input-only variant.
// Assumes the pin model in pcid_far_side and the shared package.
`timescale 1ns/1ps
`default_nettype none
module pcid_pad_cell_bench;
    import pcid_pkg::*;
    logic clock_i = 1'h0, nrst_i = 1'h0, lvl = 1'h0, drv = 1'h1;
    logic od1 = 1'h0, od2 = 1'h0, tc1 = 1'h1, tc2 = 1'h1, sr = 1'h0;
    logic ig1 = 1'h0, ig2 = 1'h0, og1 = 1'h0, og2 = 1'h0;
    logic tg1 = 1'h0, tg2 = 1'h0, coarse = 1'h0;
    logic [2:0] dtap = 3'h0;
    logic [1:0] rtap = 2'h0;
    logic [INV_W-1:0] inv = '0;
    logic [LATCH_W-1:0] lat = '0;
    logic oreg = 1'h0, osec = 1'h0, treg = 1'h0, tsec = 1'h0;
    logic pin, pout, poe_n, dir, cq1, cq2, pout2, poe2_n, dir2;
    int n_fail = 0;
    int comparisons = 0;
    int base = 0;
    always #12.5 clock_i = ~clock_i;
    pcid_far_side far (.pad_out_i(pout), .pad_oe_n_i(poe_n),
        .drive_en_i(drv), .level_i(lvl), .pad_in_o(pin));
    pcid_pad_cell dut (.clock_i(clock_i), .nrst_i(nrst_i), .pad_in_i(pin),
        .pad_out_o(pout), .pad_oe_n_o(poe_n), .out_data_first_i(od1),
        .out_data_second_i(od2), .tristate_ctl_first_i(tc1),
        .tristate_ctl_second_i(tc2), .in_gate_first_i(ig1),
        .in_gate_second_i(ig2), .out_gate_first_i(og1),
        .out_gate_second_i(og2), .tri_gate_first_i(tg1),
        .tri_gate_second_i(tg2), .set_reset_i(sr), .cfg_coarse_en_i(coarse),
        .cfg_direct_tap_i(dtap), .cfg_reg_tap_i(rtap), .cfg_invert_i(inv),
        .cfg_latch_i(lat), .cfg_out_reg_i(oreg), .cfg_out_second_i(osec),
        .cfg_tri_reg_i(treg), .cfg_tri_second_i(tsec), .direct_o(dir),
        .captured_first_o(cq1), .captured_second_o(cq2));
    pcid_pad_cell #(.HAS_OUTPUT(1'b0)) dut_in (.clock_i(clock_i),
        .nrst_i(nrst_i), .pad_in_i(lvl), .pad_out_o(pout2),
        .pad_oe_n_o(poe2_n), .out_data_first_i(od1),
        .out_data_second_i(od2), .tristate_ctl_first_i(tc1),
        .tristate_ctl_second_i(tc2), .in_gate_first_i(ig1),
        .in_gate_second_i(ig2), .out_gate_first_i(og1),
        .out_gate_second_i(og2), .tri_gate_first_i(tg1),
        .tri_gate_second_i(tg2), .set_reset_i(sr), .cfg_coarse_en_i(coarse),
        .cfg_direct_tap_i(dtap), .cfg_reg_tap_i(rtap), .cfg_invert_i(inv),
        .cfg_latch_i(lat), .cfg_out_reg_i(oreg), .cfg_out_second_i(osec),
        .cfg_tri_reg_i(treg), .cfg_tri_second_i(tsec), .direct_o(dir2),
        .captured_first_o(), .captured_second_o());
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(string name, logic exp, logic got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic chk_n(string name, int exp, int got);
        comparisons++;
        if (got != exp) begin
            n_fail++;
            $display("[ERR] %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clock_i);
        #2;
    endtask
    task automatic wrap_up;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Configuration is taken at the first edge after release only.
    task automatic restart;
        nrst_i = 1'h0;
        tick(8);
        chk("reset pad_out", OUT_RESET, pout);
        chk("reset pad_oe_n", OE_N_RESET, poe_n);
        chk("reset direct", 1'h0, dir);
        nrst_i = 1'h1;
        tick(3);
    endtask
    // Edges from a pad change until the direct output follows it.
    task automatic meas(output int l);
        logic e;
        lvl = ~lvl;
        e = lvl ^ inv[INV_PAD];
        l = 0;
        while (dir !== e && l < 40) begin
            tick(1);
            l++;
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_direct;
        int l;
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 8; k++) begin
                coarse = c[0];
                dtap = k[2:0];
                restart();
                tick(20);
                meas(l);
                if (c == 0 && k == 0) base = l;
                chk_n("direct delay", base + (k > 6 ? 6 : k)
                    + c * COARSE_LEN, l);
            end
        end
        chk_n("base delay", 1, int'(base >= 2 && base <= 4));
    endtask
    task automatic t_fixed;
        int l;
        coarse = 1'h0;
        dtap = 3'h2;
        restart();
        dtap = 3'h5;
        coarse = 1'h1;
        tick(20);
        meas(l);
        chk_n("config held", base + 2, l);
        lvl = 1'h0;
        drv = 1'h0;
        tick(20);
        chk("pulled-up pad", 1'h1, dir);
        drv = 1'h1;
        dtap = 3'h0;
        coarse = 1'h0;
    endtask
    task automatic t_invert;
        inv[INV_PAD] = 1'h1;
        inv[INV_OD1] = 1'h1;
        inv[INV_TC1] = 1'h1;
        restart();
        tick(20);
        chk("inverted drive", 1'h0, poe_n);
        chk("inverted data", 1'h1, pout);
        chk("inverted pad", 1'h0, dir);
        inv = '0;
    endtask
    task automatic t_reg(logic c, logic [1:0] s);
        int t, n;
        t = (s == 2'h0) ? 0 : (s == 2'h1) ? 3 : 6;
        coarse = c;
        rtap = s;
        lvl = 1'h0;
        restart();
        tick(20);
        n = base - 2 + t + (c ? COARSE_LEN : 0);
        lvl = 1'h1;
        tick(n);
        ig1 = 1'h1;
        tick(1);
        ig1 = 1'h0;
        ig2 = 1'h1;
        tick(1);
        ig2 = 1'h0;
        chk("early first", 1'h0, cq1);
        tick(1);
        chk("late second", 1'h1, cq2);
        ig1 = 1'h1;
        tick(1);
        ig1 = 1'h0;
        tick(1);
        chk("late first", 1'h1, cq1);
        chk("held second", 1'h1, cq2);
    endtask
    task automatic t_out;
        for (int m = 0; m < 4; m++) begin
            osec = m[0];
            tsec = m[1];
            restart();
            for (int j = 0; j < 8; j++) begin
                od1 = j[0];
                od2 = j[1];
                tc1 = j[2];
                tc2 = ~j[2];
                tick(1);
                chk("pad data", osec ? od2 : od1, pout);
                chk("pad enable", tsec ? tc2 : tc1, poe_n);
            end
        end
        tc1 = 1'h1;
        tc2 = 1'h1;
        osec = 1'h0;
    endtask
    task automatic t_store;
        oreg = 1'h1;
        treg = 1'h1;
        tsec = 1'h1;
        od1 = 1'h1;
        restart();
        tick(2);
        chk("unloaded data", 1'h0, pout);
        chk("unloaded enable", 1'h0, poe_n);
        og1 = 1'h1;
        tg2 = 1'h1;
        tick(3);
        chk("loaded data", 1'h1, pout);
        chk("loaded enable", 1'h1, poe_n);
        od1 = 1'h0;
        tc2 = 1'h0;
        tick(3);
        chk("edge only", 1'h1, pout);
        sr = 1'h1;
        tick(1);
        sr = 1'h0;
        tick(2);
        chk("cleared data", 1'h0, pout);
        chk("cleared enable", 1'h0, poe_n);
        lat[LATCH_OUT] = 1'h1;
        lat[LATCH_TRI+1] = 1'h1;
        restart();
        od1 = 1'h1;
        tc2 = 1'h1;
        tick(3);
        chk("latch open", 1'h1, pout);
        chk("latch open enable", 1'h1, poe_n);
        og1 = 1'h0;
        tg2 = 1'h0;
        od1 = 1'h0;
        tc2 = 1'h0;
        tick(3);
        chk("latch shut", 1'h1, pout);
        chk("latch shut enable", 1'h1, poe_n);
        lat = '0;
        oreg = 1'h0;
        treg = 1'h0;
        tsec = 1'h0;
        tc1 = 1'h1;
        tc2 = 1'h1;
    endtask
    task automatic t_inonly;
        od1 = 1'h1;
        tc1 = 1'h0;
        lvl = 1'h1;
        restart();
        tick(20);
        chk("input-only enable", 1'h1, poe2_n);
        chk("input-only data", 1'h0, pout2);
        chk("input-only direct", 1'h1, dir2);
    endtask
    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        t_direct();
        t_fixed();
        t_invert();
        for (int q = 0; q < 8; q++) begin
            t_reg(q[2], q[1:0]);
        end
        t_out();
        t_store();
        t_inonly();
        wrap_up();
    end
    initial begin
        #(25 * 20000);
        n_fail++;
        wrap_up();
    end
endmodule
`default_nettype wire
